// ### logic/tcr_pkg.sv
/*
  Constants for the timer, port and oscillator configuration register bank.
  Assumes a single system clock and instruction-driven access from the core.
*/
package tcr_pkg;
  // Register pages reached by the core's page read and write instructions.
  localparam logic [1:0] PAGE_F = 2'h0;
  localparam logic [1:0] PAGE_S = 2'h1;
  // Page F offsets.
  localparam logic [3:0] OFS_PORT_DIRECTION  = 4'h6;
  localparam logic [3:0] OFS_PRESCALER_COUNT = 4'hA;
  localparam logic [3:0] OFS_OPEN_DRAIN      = 4'hC;
  localparam logic [3:0] OFS_POWER_CTRL2     = 4'hF;
  // Page S offsets.
  localparam logic [3:0] OFS_TABLE_ADDR_HIGH = 4'h7;
  localparam logic [3:0] OFS_TABLE_DATA_HIGH = 4'h8;
  localparam logic [3:0] OFS_OSC_CTRL        = 4'hF;
  // Timer mode field positions.
  localparam int TM_RATIO_LSB = 0;
  localparam int TM_ASSIGN    = 3;
  localparam int TM_EDGE      = 4;
  localparam int TM_SOURCE    = 5;
  localparam int TM_EXT_EDGE  = 6;
  localparam int TM_LOWCLK    = 7;
  // Power control field positions.
  localparam int PC_TIMER_EN  = 0;
  localparam int PC_GIE       = 7;
  // Oscillator control field positions.
  localparam int OC_SEL_HIGH  = 0;
  localparam int OC_STOP_HIGH = 1;
  localparam int OC_MODE_LSB  = 2;
  // Implemented bits and reset values.
  localparam logic [7:0] DIR_MASK      = 8'h3F;
  localparam logic [7:0] OD_MASK       = 8'h37;
  localparam logic [7:0] RST_TMODE     = 8'h3F;
  localparam logic [7:0] RST_DIR       = 8'h3F;
  localparam logic [7:0] RST_OD        = 8'h00;
  localparam logic [7:0] RST_PRESCALER = 8'hFF;
  localparam logic       RST_TIMER_EN  = 1'b1;
  localparam logic       RST_GIE       = 1'b0;
  localparam logic       RST_SEL_HIGH  = 1'b1;
  localparam logic       RST_STOP_HIGH = 1'b0;
  // Operating modes.
  typedef enum logic [1:0] {
    TCR_MODE_NORMAL   = 2'h0,
    TCR_MODE_HALT     = 2'h1,
    TCR_MODE_STANDBY  = 2'h2,
    TCR_MODE_RESERVED = 2'h3
  } tcr_mode_t;
endpackage

// ### logic/tcr_regs.sv
/*
  Configuration register bank: timer mode, port direction and open drain,
  prescaler with readback, timer and interrupt enables, table pointer and
  data, oscillator and operating mode control.
  Assumes the core issues one-cycle instruction strobes synchronous to clk.
*/
`timescale 1ns/1ps
module tcr_regs (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [1:0]  reg_page,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic        tmode_wr,
  input  wire logic        tmode_rd,
  input  wire logic        enable_interrupts_instruction,
  input  wire logic        disable_interrupts_instruction,
  input  wire logic        table_read,
  input  wire logic [13:0] rom_word,
  input  wire logic [7:0]  accumulator,
  output logic      [8:0]  target_address,
  output logic             acc_load,
  output logic      [7:0]  acc_data,
  input  wire logic        instr_clk_tick,
  input  wire logic        external_clock_pin,
  input  wire logic        low_freq_oscillator,
  input  wire logic        ext_interrupt_pin,
  output logic             timer_tick,
  output logic             wdt_tick,
  output logic             ext_interrupt_flag_set,
  output logic      [5:0]  pin_direction,
  output logic      [5:0]  pin_open_drain,
  output logic             global_interrupt_enable,
  output logic             timer_enable,
  output logic             oscillator_select,
  output logic             high_oscillator_stop,
  output tcr_pkg::tcr_mode_t operating_mode
);

  //////////////////////////////////////////////////////////////////////////
  // Storage.
  logic [7:0] tmode_q;
  logic [7:0] dir_q;
  logic [7:0] od_q;
  logic [7:0] psc_q;
  logic [7:0] psc_d;
  logic       table_address_high_q;
  logic [5:0] table_data_high_q;
  logic       ten_q;
  logic       gie_q;
  logic       sel_q;
  logic       stop_q;
  tcr_pkg::tcr_mode_t mode_q;
  logic       clk_prev_q;
  logic       int_prev_q;
  logic       psc_clr_q;
  logic       src_level;
  logic       src_edge;
  logic       src_tick;
  logic       div_out;
  logic       wr_f;
  logic       wr_s;

  // Mask of low counter bits that must wrap to zero for one divided tick.
  function automatic logic [7:0] div_mask(input logic [2:0] code, input logic to_wdt);
    logic [8:0] full;
    full = to_wdt ? (9'h001 << code) : (9'h002 << code);
    div_mask = 8'(full - 9'h001);
  endfunction

  assign wr_f = reg_wr && (reg_page == tcr_pkg::PAGE_F);
  assign wr_s = reg_wr && (reg_page == tcr_pkg::PAGE_S);

  //////////////////////////////////////////////////////////////////////////
  // Timer mode register, written only by its dedicated instruction.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tmode_q <= tcr_pkg::RST_TMODE;
    end else if (tmode_wr) begin
      tmode_q <= reg_wdata;
    end
  end

  // A write that gives the prescaler to the timer clears it next cycle.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      psc_clr_q <= 1'b0;
    end else begin
      psc_clr_q <= tmode_wr && !reg_wdata[tcr_pkg::TM_ASSIGN];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Port direction and open drain; unimplemented bits are dropped.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dir_q <= tcr_pkg::RST_DIR;
      od_q  <= tcr_pkg::RST_OD;
    end else if (wr_f) begin
      if (reg_addr == tcr_pkg::OFS_PORT_DIRECTION) begin
        dir_q <= reg_wdata & tcr_pkg::DIR_MASK;
      end
      if (reg_addr == tcr_pkg::OFS_OPEN_DRAIN) begin
        od_q <= reg_wdata & tcr_pkg::OD_MASK;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Timer enable and global interrupt enable; enable instruction wins.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ten_q <= tcr_pkg::RST_TIMER_EN;
      gie_q <= tcr_pkg::RST_GIE;
    end else begin
      if (wr_f && reg_addr == tcr_pkg::OFS_POWER_CTRL2) begin
        ten_q <= reg_wdata[tcr_pkg::PC_TIMER_EN];
      end
      if (enable_interrupts_instruction) begin
        gie_q <= 1'b1;
      end else if (disable_interrupts_instruction) begin
        gie_q <= 1'b0;
      end else if (wr_f && reg_addr == tcr_pkg::OFS_POWER_CTRL2) begin
        gie_q <= reg_wdata[tcr_pkg::PC_GIE];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Table pointer, table data and accumulator load.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      table_address_high_q   <= 1'b0;
      table_data_high_q   <= 6'h00;
      acc_load <= 1'b0;
      acc_data <= 8'h00;
    end else begin
      if (wr_s && reg_addr == tcr_pkg::OFS_TABLE_ADDR_HIGH) begin
        table_address_high_q <= reg_wdata[0];
      end
      acc_load <= table_read;
      if (table_read) begin
        table_data_high_q   <= rom_word[13:8];
        acc_data <= rom_word[7:0];
      end
    end
  end

  // Target of indirect call, jump and table read.
  assign target_address = {table_address_high_q, accumulator};

  //////////////////////////////////////////////////////////////////////////
  // Oscillator control; a reserved mode code falls back to normal.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_q  <= tcr_pkg::RST_SEL_HIGH;
      stop_q <= tcr_pkg::RST_STOP_HIGH;
      mode_q <= tcr_pkg::TCR_MODE_NORMAL;
    end else if (wr_s && reg_addr == tcr_pkg::OFS_OSC_CTRL) begin
      sel_q  <= reg_wdata[tcr_pkg::OC_SEL_HIGH];
      stop_q <= reg_wdata[tcr_pkg::OC_STOP_HIGH];
      case (tcr_pkg::tcr_mode_t'(reg_wdata[tcr_pkg::OC_MODE_LSB +: 2]))
        tcr_pkg::TCR_MODE_HALT:    mode_q <= tcr_pkg::TCR_MODE_HALT;
        tcr_pkg::TCR_MODE_STANDBY: mode_q <= tcr_pkg::TCR_MODE_STANDBY;
        default:                   mode_q <= tcr_pkg::TCR_MODE_NORMAL;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Timer clock source selection and active edge detection.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      clk_prev_q <= 1'b0;
      int_prev_q <= 1'b0;
    end else begin
      clk_prev_q <= src_level;
      int_prev_q <= ext_interrupt_pin;
    end
  end

  assign src_level = tmode_q[tcr_pkg::TM_LOWCLK] ? low_freq_oscillator
                                                 : external_clock_pin;
  assign src_edge  = tmode_q[tcr_pkg::TM_EDGE] ? (clk_prev_q && !src_level)
                                               : (!clk_prev_q && src_level);
  assign src_tick  = tmode_q[tcr_pkg::TM_SOURCE] ? src_edge : instr_clk_tick;

  // External interrupt flag set pulse on the selected edge.
  assign ext_interrupt_flag_set = tmode_q[tcr_pkg::TM_EXT_EDGE]
                                  ? (!int_prev_q && ext_interrupt_pin)
                                  : (int_prev_q && !ext_interrupt_pin);

  //////////////////////////////////////////////////////////////////////////
  // Shared prescaler counter; counts source ticks for the timer or the watchdog.
  always_comb begin
    psc_d = psc_q;
    if (src_tick) begin
      psc_d = psc_q + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      psc_q <= tcr_pkg::RST_PRESCALER;
    end else if (psc_clr_q) begin
      psc_q <= 8'h00;
    end else begin
      psc_q <= psc_d;
    end
  end

  // Divided tick when the selected low bits wrap to zero.
  assign div_out = src_tick && ((psc_d & div_mask(tmode_q[2:0],
                   tmode_q[tcr_pkg::TM_ASSIGN])) == 8'h00);

  // Route the prescaler to the watchdog or the timer.
  assign timer_tick = ten_q && (tmode_q[tcr_pkg::TM_ASSIGN] ? src_tick
                                                            : div_out);
  assign wdt_tick   = tmode_q[tcr_pkg::TM_ASSIGN] && div_out;

  //////////////////////////////////////////////////////////////////////////
  // Registered read data; unmapped offsets and missing bits read zero.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (tmode_rd) begin
      reg_rdata <= tmode_q;
    end else if (reg_rd && reg_page == tcr_pkg::PAGE_F) begin
      case (reg_addr)
        tcr_pkg::OFS_PORT_DIRECTION:  reg_rdata <= dir_q;
        tcr_pkg::OFS_PRESCALER_COUNT: reg_rdata <= psc_q;
        tcr_pkg::OFS_OPEN_DRAIN:      reg_rdata <= od_q;
        tcr_pkg::OFS_POWER_CTRL2:     reg_rdata <= {gie_q, 6'h00, ten_q};
        default:                      reg_rdata <= 8'h00;
      endcase
    end else if (reg_rd && reg_page == tcr_pkg::PAGE_S) begin
      case (reg_addr)
        tcr_pkg::OFS_TABLE_ADDR_HIGH: reg_rdata <= {7'h00, table_address_high_q};
        tcr_pkg::OFS_TABLE_DATA_HIGH: reg_rdata <= {2'h0, table_data_high_q};
        tcr_pkg::OFS_OSC_CTRL:        reg_rdata <= {4'h0, mode_q, stop_q, sel_q};
        default:                      reg_rdata <= 8'h00;
      endcase
    end else if (reg_rd) begin
      reg_rdata <= 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Configuration outputs.
  assign pin_direction           = dir_q[5:0];
  assign pin_open_drain          = od_q[5:0];
  assign global_interrupt_enable = gie_q;
  assign timer_enable            = ten_q;
  assign oscillator_select       = sel_q;
  assign high_oscillator_stop    = stop_q;
  assign operating_mode          = mode_q;

  //////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_tmode_isolated: assert property (
    !tmode_wr |=> $stable(tmode_q)) else $error("timer mode changed without its write");
  a_psc_clear: assert property (
    tmode_wr && !reg_wdata[3] ##1 1'b1 |=> psc_q == 8'h00)
    else $error("prescaler not cleared after assignment to timer");
  a_timer_div2: assert property (
    ten_q && tmode_q[3:0] == 4'h0 && src_tick |-> timer_tick == psc_q[0])
    else $error("timer ratio two wrong");
  a_wdt_div1: assert property (
    tmode_q[3:0] == 4'h8 && src_tick |-> wdt_tick) else $error("watchdog ratio one wrong");
  a_route_wdt: assert property (
    tmode_q[3] |-> timer_tick == (ten_q && src_tick)) else $error("prescaler routing wrong");
  a_ext_fall: assert property (
    !tmode_q[7] && tmode_q[5:3] == 3'h7 && ten_q && $fell(external_clock_pin)
      && $stable(tmode_q) |-> timer_tick)
    else $error("external falling edge not counted");
  a_timer_stop: assert property (
    !ten_q |-> !timer_tick) else $error("timer ticked while disabled");
  a_int_edge: assert property (
    tmode_q[6] && $rose(ext_interrupt_pin) |-> ext_interrupt_flag_set)
    else $error("external interrupt edge missed");
  a_gie_instr: assert property (
    enable_interrupts_instruction |=> gie_q ##0 global_interrupt_enable) else $error("enable instruction ignored");
  a_mode_rsvd: assert property (
    wr_s && reg_addr == 4'hF && reg_wdata[3:2] == 2'h3 |=> mode_q == tcr_pkg::TCR_MODE_NORMAL)
    else $error("reserved mode not mapped to normal");
  a_table_load: assert property (
    table_read |=> acc_load && table_data_high_q == $past(rom_word[13:8])) else $error("table load wrong");

  c_table_read: cover property (table_read ##1 acc_load);
  c_wdt_tick:   cover property (wdt_tick);
  c_ext_int:    cover property (ext_interrupt_flag_set);

endmodule // tcr_regs

// ### testbench/tcr_regs_tb.sv
/*
  Self-checking bench for the configuration register bank: row table, then prescaler,
  clock source, interrupt edge, table read and reset cases.
  Assumes the bank as declared in logic/ and a 10 MHz clock.
*/
`timescale 1ns/1ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin mismatches++; \
  $display("Error at %0t ns: got %h expected %h", $time, got, exp); end end
module tcr_regs_tb;
  typedef struct packed {logic [1:0] pg; logic [3:0] ad;
                         logic [7:0] wd; logic [7:0] ex;} tcr_row_t;
  localparam int TIMEOUT = 20000;
  localparam tcr_row_t ROWS [16] = '{
    '{2'h0, 4'h6, 8'hFF, 8'h3F},
    '{2'h0, 4'h6, 8'hC5, 8'h05},
    '{2'h0, 4'hC, 8'hFF, 8'h37},
    '{2'h0, 4'hA, 8'h00, 8'hFF},
    '{2'h0, 4'hF, 8'hFE, 8'h80},
    '{2'h0, 4'hF, 8'h01, 8'h01},
    '{2'h1, 4'h7, 8'hFF, 8'h01},
    '{2'h1, 4'hF, 8'h09, 8'h09},
    '{2'h1, 4'hF, 8'h05, 8'h05},
    '{2'h1, 4'hF, 8'h0D, 8'h01},
    '{2'h1, 4'hF, 8'h00, 8'h00},
    '{2'h1, 4'hF, 8'h02, 8'h02},
    '{2'h1, 4'hF, 8'h00, 8'h00},
    '{2'h1, 4'hF, 8'hF1, 8'h01},
    '{2'h0, 4'h0, 8'hFF, 8'h00},
    '{2'h2, 4'h6, 8'h00, 8'h00}};
  logic               clk, reset_n, reg_wr, reg_rd, tmode_wr, tmode_rd, enable_interrupts_instruction, disable_interrupts_instruction, table_read;
  logic        [1:0]  reg_page;
  logic        [3:0]  reg_addr;
  logic        [7:0]  reg_wdata, reg_rdata, accumulator, acc_data, tm;
  logic        [13:0] rom_word;
  logic        [8:0]  target_address;
  logic               acc_load, instr_clk_tick, external_clock_pin, low_freq_oscillator;
  logic               ext_interrupt_pin, timer_tick, wdt_tick, ext_interrupt_flag_set;
  logic        [5:0]  pin_direction, pin_open_drain;
  logic               global_interrupt_enable, timer_enable, oscillator_select;
  logic               high_oscillator_stop;
  tcr_pkg::tcr_mode_t operating_mode;
  int                 mismatches, cmp_count, cycles, nt, nw;

  tcr_regs uut (.clk(clk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_page(reg_page), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .tmode_wr(tmode_wr), .tmode_rd(tmode_rd), .enable_interrupts_instruction(enable_interrupts_instruction), .disable_interrupts_instruction(disable_interrupts_instruction), .table_read(table_read),
    .rom_word(rom_word), .accumulator(accumulator), .target_address(target_address),
    .acc_load(acc_load), .acc_data(acc_data), .instr_clk_tick(instr_clk_tick),
    .external_clock_pin(external_clock_pin), .low_freq_oscillator(low_freq_oscillator),
    .ext_interrupt_pin(ext_interrupt_pin), .timer_tick(timer_tick), .wdt_tick(wdt_tick),
    .ext_interrupt_flag_set(ext_interrupt_flag_set), .pin_direction(pin_direction),
    .pin_open_drain(pin_open_drain), .global_interrupt_enable(global_interrupt_enable),
    .timer_enable(timer_enable), .oscillator_select(oscillator_select),
    .high_oscillator_stop(high_oscillator_stop), .operating_mode(operating_mode));

  ////////////////////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Each strobe task starts at a falling edge and leaves one idle cycle after it.
  task automatic wr_reg(input logic [1:0] pg, input logic [3:0] ad, input logic [7:0] wd);
    reg_page = pg; reg_addr = ad; reg_wdata = wd; reg_wr = 1'b1;
    @(negedge clk); reg_wr = 1'b0; @(negedge clk);
  endtask

  // Reads a page register; data is registered at the edge that takes the strobe.
  task automatic rd_reg(input logic [1:0] pg, input logic [3:0] ad, input logic [7:0] ex);
    reg_page = pg; reg_addr = ad; reg_rd = 1'b1;
    @(negedge clk); reg_rd = 1'b0; `CHK(reg_rdata, ex) @(negedge clk);
  endtask

  task automatic wr_tmode(input logic [7:0] wd);
    reg_wdata = wd; tmode_wr = 1'b1; @(negedge clk); tmode_wr = 1'b0; @(negedge clk);
  endtask

  task automatic rd_tmode(input logic [7:0] ex);
    tmode_rd = 1'b1; @(negedge clk); tmode_rd = 1'b0; `CHK(reg_rdata, ex) @(negedge clk);
  endtask

  // Runs 256 instruction ticks; any 256 increments hold exactly 256/ratio divided ticks.
  task automatic count_ticks();
    nt = 0; nw = 0; instr_clk_tick = 1'b1;
    repeat (256) begin #1; nt += timer_tick; nw += wdt_tick; @(negedge clk); end
    instr_clk_tick = 1'b0;
  endtask

  // Moves pin and interrupt pin to lvl and the low oscillator opposite, checks both pulses.
  task automatic src_step(input logic lvl);
    logic ps, cs, pi;
    ps = tm[7] ? low_freq_oscillator : external_clock_pin;
    pi = ext_interrupt_pin;
    cs = tm[7] ? ~lvl : lvl;
    external_clock_pin = lvl; low_freq_oscillator = ~lvl; ext_interrupt_pin = lvl;
    #1;
    `CHK(timer_tick, tm[4] ? (ps & ~cs) : (~ps & cs))
    `CHK(ext_interrupt_flag_set, tm[6] ? (~pi & lvl) : (pi & ~lvl))
    @(negedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////
  // Makes the 100 ns clock.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Cuts a hang short by counting a mismatch and closing the run.
  always @(posedge clk) begin
    cycles++;
    if (cycles == TIMEOUT) begin mismatches++; give_verdict(); end
  end

  // Main sequence.
  initial begin
    {reg_wr, reg_rd, tmode_wr, tmode_rd, enable_interrupts_instruction, disable_interrupts_instruction, table_read, instr_clk_tick} = 8'h00;
    {external_clock_pin, low_freq_oscillator, ext_interrupt_pin, reset_n} = 4'h0;
    reg_page = 2'h0; reg_addr = 4'h0; reg_wdata = 8'h00; rom_word = 14'h0000;
    accumulator = 8'h00; tm = 8'h00; mismatches = 0; cmp_count = 0; cycles = 0;
    repeat (12) @(negedge clk);
    reset_n = 1'b1;
    `CHK({pin_direction, pin_open_drain}, 12'hFC0)
    `CHK({timer_enable, global_interrupt_enable}, 2'h2)
    `CHK({oscillator_select, high_oscillator_stop}, 2'h2)
    `CHK(operating_mode, tcr_pkg::TCR_MODE_NORMAL)
    rd_tmode(8'h3F);
    rd_reg(2'h1, 4'hF, 8'h01);
    rd_reg(2'h0, 4'hF, 8'h01);
    foreach (ROWS[i]) begin
      wr_reg(ROWS[i].pg, ROWS[i].ad, ROWS[i].wd);
      rd_reg(ROWS[i].pg, ROWS[i].ad, ROWS[i].ex);
      if (ROWS[i].pg == 2'h1 && ROWS[i].ad == 4'hF) begin
        `CHK(operating_mode, tcr_pkg::tcr_mode_t'(ROWS[i].ex[3:2]))
        `CHK({high_oscillator_stop, oscillator_select}, ROWS[i].ex[1:0])
      end
    end
    `CHK({pin_direction, pin_open_drain}, 12'h177)
    // Enable and disable strobes, alone and together.
    for (int k = 1; k < 4; k++) begin
      {enable_interrupts_instruction, disable_interrupts_instruction} = k[1:0]; @(negedge clk); {enable_interrupts_instruction, disable_interrupts_instruction} = 2'h0;
      `CHK(global_interrupt_enable, k[1])
      rd_reg(2'h0, 4'hF, {k[1], 7'h01});
    end
    wr_tmode(8'hA5);
    rd_tmode(8'hA5);
    // Prescaler on the timer and on the watchdog, every ratio code.
    for (int k = 0; k < 8; k++) begin
      wr_tmode({5'h00, k[2:0]});
      rd_reg(2'h0, 4'hA, 8'h00);
      count_ticks();
      `CHK(nt, 256 >> (k + 1))
      wr_tmode({5'h01, k[2:0]});
      count_ticks();
      `CHK(nt, 256)
      `CHK(nw, 256 >> k)
    end
    // External sources, both edges and both interrupt edges.
    for (int m = 0; m < 4; m++) begin
      tm = {m[1], m[0] ^ m[1], 1'b1, m[0], 4'h8};
      wr_tmode(tm);
      src_step(1'b1); src_step(1'b0); src_step(1'b0); src_step(1'b1); src_step(1'b0);
    end
    // Indirect target and table read.
    accumulator = 8'hC3; wr_reg(2'h1, 4'h7, 8'h01);
    `CHK(target_address, 9'h1C3)
    wr_reg(2'h1, 4'h7, 8'h00);
    `CHK(target_address, 9'h0C3)
    rom_word = 14'h3A5C; table_read = 1'b1; @(negedge clk); table_read = 1'b0;
    `CHK({acc_load, acc_data}, 9'h15C)
    @(negedge clk);
    `CHK(acc_load, 1'b0)
    rd_reg(2'h1, 4'h8, 8'h3A);
    // Second reset in mid-run returns the defaults.
    reset_n = 1'b0; @(negedge clk);
    `CHK({pin_direction, pin_open_drain, global_interrupt_enable}, 13'h1F80)
    reset_n = 1'b1;
    rd_tmode(8'h3F);
    rd_reg(2'h0, 4'hA, 8'hFF);
    give_verdict();
  end
endmodule // tcr_regs_tb
